// File: hdl/hspl_top.sv
// hspl_top.sv: pin logic of a hot-swap controller with a Wishbone slave.
// assumes: all inputs synchronous to clk_i; analog comparators and
// fault detectors outside deliver clean levels; the board pulls pins up.
//
// Functional notes
// R01 - gate off on supply out of window or any active fault
// R02 - undervoltage low or overvoltage high switches transistor off
// R03 - power good only when output settled, fully enhanced, no fault
// R04 - configuration picks power good active polarity
// R05 - general out 0 is plain, fault or alert, open-drain
// R06 - fault function drives programmable level on masked faults
// R07 - alert pin pulls low on selected faults or warnings
// R08 - general out 1 is plain, warning or lamp; warning after reset
// R09 - warning function drives programmable level on masked warnings
// R10 - lamp function pulls low on masked faults
// R11 - connector good, when enabled, permits turn-on only while held low
// R12 - general pin 3 as bus enable gates bus traffic; off by default
// R13 - host keeps serial clock at or under 1 MHz
// R14 - serial data read on one pin, driven on separate open-drain pin
// R15 - two address straps decode to one of 16 addresses; the code decodes only 9 (three levels per strap)
// R16 - mode straps pick fixed or adaptive; both open means fixed
// R17 - startup current setting applies only in adaptive mode
// R18 - each output goes through mux, inverter, then open-drain; general pins 2 and 3 have no inverter and only pull low on alert
//
// Design decisions made here: the Wishbone register port and the register offsets.
`default_nettype none
`include "hspl_params.svh"
module hspl_top
  import hspl_pkg::*;
#(
  parameter int FAULTS = 8,
  parameter int WARNS  = 8
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic        [7:0] adr_i,
  input  wire logic        [3:0] sel_i,
  input  wire logic       [31:0] dat_i,
  output logic            [31:0] dat_o,
  output logic                   ack_o,
  // analog comparator and detector levels
  input  wire logic              undervolt_enable_in_i,
  input  wire logic              overvolt_in_i,
  input  wire logic              output_settled_i,
  input  wire logic              gate_enhanced_i,
  input  wire logic [FAULTS-1:0] fault_i,
  input  wire logic  [WARNS-1:0] warn_i,
  input  wire logic              gate_request_i,
  input  wire logic        [3:0] startup_current_set_i,
  // straps
  input  wire logic        [1:0] addr_strap_0_i,
  input  wire logic        [1:0] addr_strap_1_i,
  input  wire logic        [1:0] mode_strap_0_i,
  input  wire logic        [1:0] mode_strap_1_i,
  // serial data, split for isolators
  input  wire logic              serial_data_in_i,
  input  wire logic              serial_data_drive_low_i,
  output logic                   serial_data_in_o,
  output logic                   serial_data_out_oe_n_o,
  output logic                   bus_enable_o,
  // pins and gate
  output logic                   gate_on_o,
  output logic                   power_good_out_oe_n_o,
  output logic                   general_out_0_oe_n_o,
  output logic                   general_out_1_oe_n_o,
  input  wire logic              general_pin_2_i,
  output logic                   general_pin_2_oe_n_o,
  input  wire logic              general_pin_3_i,
  output logic                   general_pin_3_oe_n_o,
  output logic             [6:0] bus_addr_o,
  output logic                   adaptive_mode_o,
  output logic             [3:0] startup_limit_o
);
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (FAULTS < 1 || FAULTS > 8) begin : g_bad_faults
    $error("FAULTS must be 1 to 8");
  end
  if (WARNS < 1 || WARNS > 8) begin : g_bad_warns
    $error("WARNS must be 1 to 8");
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] cfg_q;
  logic  [7:0] flt_mask_q;
  logic  [7:0] wrn_mask_q;
  logic  [7:0] alt_mask_q;
  logic [31:0] rd_d;
  logic        wb_req;
  logic        wb_wr;
  logic        strap_valid;

  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign wb_req = cyc_i && stb_i && !ack_o;
  assign wb_wr  = wb_req && we_i;

  // bus acknowledge, one cycle after request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= wb_req;
    end
  end

  // control and configuration writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q     <= `HSPL_CTRL_RST;
      // R08 warning after reset
      cfg_q      <= `HSPL_CFG_RST;
      flt_mask_q <= `HSPL_MASK_RST;
      wrn_mask_q <= `HSPL_MASK_RST;
      alt_mask_q <= `HSPL_MASK_RST;
    end else if (wb_wr) begin
      unique case (adr_i)
        `HSPL_OFF_CTRL:     ctrl_q     <= merge(ctrl_q, dat_i, sel_i);
        `HSPL_OFF_GPO_CFG:  cfg_q      <= merge(cfg_q, dat_i, sel_i);
        `HSPL_OFF_FLT_MASK: flt_mask_q <= sel_i[0] ? dat_i[7:0] : flt_mask_q;
        `HSPL_OFF_WRN_MASK: wrn_mask_q <= sel_i[0] ? dat_i[7:0] : wrn_mask_q;
        `HSPL_OFF_ALT_MASK: alt_mask_q <= sel_i[0] ? dat_i[7:0] : alt_mask_q;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // function selection
  // ----------------------------------------------------------------
  hspl_g0_fn_t g0_fn;
  hspl_g1_fn_t g1_fn;
  hspl_gx_fn_t g2_fn;
  hspl_gx_fn_t g3_fn;
  logic [7:0]  flt_v;
  logic [7:0]  wrn_v;
  logic        any_fault;
  logic        flt_hit;
  logic        wrn_hit;
  logic        alt_hit;
  logic        supply_ok;
  logic        conn_ok;
  logic        g0_assert;
  logic        g0_pol;
  logic        g1_assert;
  logic        g1_pol;
  logic        g3_alert;

  assign g0_fn = hspl_g0_fn_t'(cfg_q[`HSPL_CFG_G0_LSB +: 2]);
  assign g1_fn = hspl_g1_fn_t'(cfg_q[`HSPL_CFG_G1_LSB +: 2]);
  assign g2_fn = hspl_gx_fn_t'(cfg_q[`HSPL_CFG_G2_LSB +: 2]);
  assign g3_fn = hspl_gx_fn_t'(cfg_q[`HSPL_CFG_G3_LSB +: 2]);
  assign flt_v = 8'(fault_i);
  assign wrn_v = 8'(warn_i);

  // raw fault summary and masked event sets
  assign any_fault = |flt_v;
  assign flt_hit   = |(flt_v & flt_mask_q);
  assign wrn_hit   = |(wrn_v & wrn_mask_q);
  // R07 alert on selection
  assign alt_hit   = |({flt_v & alt_mask_q, wrn_v & alt_mask_q});

  // R02 window comparators
  assign supply_ok = undervolt_enable_in_i && !overvolt_in_i;
  // R11 connector held low
  assign conn_ok   = (g2_fn != HSPL_GX_CONN) || !general_pin_2_i;

  // general out 0 function mux
  // R05 three functions
  // R06 programmable fault level
  always_comb begin
    g0_assert = 1'b0;
    g0_pol    = 1'b0;
    unique case (g0_fn)
      HSPL_G0_PLAIN: begin
        g0_assert = ctrl_q[`HSPL_CTRL_G0_PLAIN];
        g0_pol    = 1'b1;
      end
      HSPL_G0_FAULT: begin
        g0_assert = flt_hit;
        g0_pol    = ctrl_q[`HSPL_CTRL_G0_LVL];
      end
      HSPL_G0_ALERT: begin
        g0_assert = alt_hit;
        g0_pol    = 1'b0;
      end
      default: begin
        g0_assert = 1'b0;
        g0_pol    = 1'b0;
      end
    endcase
  end

  // general out 1 function mux
  // R09 programmable warning level
  // R10 lamp pulls low
  always_comb begin
    g1_assert = 1'b0;
    g1_pol    = 1'b0;
    unique case (g1_fn)
      HSPL_G1_PLAIN: begin
        g1_assert = ctrl_q[`HSPL_CTRL_G1_PLAIN];
        g1_pol    = 1'b1;
      end
      HSPL_G1_WARN: begin
        g1_assert = wrn_hit;
        g1_pol    = ctrl_q[`HSPL_CTRL_G1_LVL];
      end
      HSPL_G1_LAMP: begin
        g1_assert = flt_hit;
        g1_pol    = 1'b0;
      end
      default: begin
        g1_assert = 1'b0;
        g1_pol    = 1'b0;
      end
    endcase
  end

  assign g3_alert = (g3_fn == HSPL_GX_ALERT) && alt_hit;

  // ----------------------------------------------------------------
  // gate and power good
  // ----------------------------------------------------------------
  // R01 force gate low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_on_o <= 1'b0;
    end else begin
      gate_on_o <= gate_request_i && supply_ok && !any_fault && conn_ok;
    end
  end

  // R03 settled and clean
  // R04 polarity choice
  hspl_od_pin u_pg (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .assert_i         (output_settled_i && gate_enhanced_i && !any_fault && gate_on_o),
    .active_high_i    (ctrl_q[`HSPL_CTRL_PG_POL]),
    .drive_low_oe_n_o (power_good_out_oe_n_o)
  );

  // R18 open-drain outputs
  hspl_od_pin u_g0 (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .assert_i         (g0_assert),
    .active_high_i    (g0_pol),
    .drive_low_oe_n_o (general_out_0_oe_n_o)
  );

  hspl_od_pin u_g1 (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .assert_i         (g1_assert),
    .active_high_i    (g1_pol),
    .drive_low_oe_n_o (general_out_1_oe_n_o)
  );

  // pins 2 and 3: only the alert function drives them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      general_pin_2_oe_n_o <= 1'b1;
      general_pin_3_oe_n_o <= 1'b1;
    end else begin
      general_pin_2_oe_n_o <= !((g2_fn == HSPL_GX_ALERT) && alt_hit);
      general_pin_3_oe_n_o <= !g3_alert;
    end
  end

  // ----------------------------------------------------------------
  // serial data and bus enable
  // ----------------------------------------------------------------
  // R12 bus enable pin
  // R14 split data pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_enable_o           <= 1'b1;
      serial_data_in_o       <= 1'b1;
      serial_data_out_oe_n_o <= 1'b1;
    end else begin
      bus_enable_o           <= (g3_fn != HSPL_GX_BUSEN) || general_pin_3_i;
      serial_data_in_o       <= serial_data_in_i;
      serial_data_out_oe_n_o <= !(serial_data_drive_low_i &&
                                  ((g3_fn != HSPL_GX_BUSEN) || general_pin_3_i));
    end
  end

  // ----------------------------------------------------------------
  // straps
  // ----------------------------------------------------------------
  hspl_strap_decode u_strap (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .addr_strap_0_i  (addr_strap_0_i),
    .addr_strap_1_i  (addr_strap_1_i),
    .mode_strap_0_i  (mode_strap_0_i),
    .mode_strap_1_i  (mode_strap_1_i),
    .bus_addr_o      (bus_addr_o),
    .adaptive_mode_o (adaptive_mode_o),
    .valid_o         (strap_valid)
  );

  // R17 adaptive only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      startup_limit_o <= 4'h0;
    end else begin
      startup_limit_o <= adaptive_mode_o ? startup_current_set_i : 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (adr_i)
      `HSPL_OFF_CTRL:     rd_d = ctrl_q;
      `HSPL_OFF_GPO_CFG:  rd_d = cfg_q;
      `HSPL_OFF_FLT_MASK: rd_d = {24'h00_0000, flt_mask_q};
      `HSPL_OFF_WRN_MASK: rd_d = {24'h00_0000, wrn_mask_q};
      `HSPL_OFF_ALT_MASK: rd_d = {24'h00_0000, alt_mask_q};
      `HSPL_OFF_STATUS:   rd_d = {16'h0000, wrn_v, flt_v[5:0], supply_ok, gate_on_o};
      `HSPL_OFF_STRAPS:   rd_d = {20'h0_0000, strap_valid, adaptive_mode_o,
                                  3'h0, bus_addr_o};
      default:            rd_d = 32'h0000_0000;
    endcase
  end

  // read data register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (wb_req && !we_i) begin
      dat_o <= rd_d;
    end
  end
endmodule // hspl_top
`default_nettype wire

// File: hdl/hspl_params.svh
// hspl_params.svh: constants for the hot-swap status pin logic.
// assumes: included by bare name; defines only.
`ifndef HSPL_PARAMS_SVH
`define HSPL_PARAMS_SVH
// register byte offsets
`define HSPL_OFF_CTRL      8'h00
`define HSPL_OFF_GPO_CFG   8'h04
`define HSPL_OFF_FLT_MASK  8'h08
`define HSPL_OFF_WRN_MASK  8'h0c
`define HSPL_OFF_ALT_MASK  8'h10
`define HSPL_OFF_STATUS    8'h14
`define HSPL_OFF_STRAPS    8'h18
// control register fields
`define HSPL_CTRL_PG_POL   0
`define HSPL_CTRL_G0_LVL   1
`define HSPL_CTRL_G1_LVL   2
`define HSPL_CTRL_G0_PLAIN 3
`define HSPL_CTRL_G1_PLAIN 4
// gpo config fields (two bits per pin)
`define HSPL_CFG_G0_LSB    0
`define HSPL_CFG_G1_LSB    2
`define HSPL_CFG_G2_LSB    4
`define HSPL_CFG_G3_LSB    6
// reset values
`define HSPL_CTRL_RST      32'h0000_0000
`define HSPL_CFG_RST       32'h0000_0004
`define HSPL_MASK_RST      8'hff
// strap address base
`define HSPL_ADDR_BASE     7'h40
`endif

// File: hdl/hspl_pkg.sv
// hspl_pkg.sv: types for the hot-swap status pin logic.
// assumes: nothing beyond the params header.
`default_nettype none
package hspl_pkg;
  // three-level strap reading
  typedef enum logic [1:0] {
    HSPL_STRAP_GND = 2'h0,
    HSPL_STRAP_OPEN = 2'h1,
    HSPL_STRAP_RES = 2'h2
  } hspl_strap_t;
  // general output 0 functions
  typedef enum logic [1:0] {
    HSPL_G0_PLAIN = 2'h0,
    HSPL_G0_FAULT = 2'h1,
    HSPL_G0_ALERT = 2'h2
  } hspl_g0_fn_t;
  // general output 1 functions
  typedef enum logic [1:0] {
    HSPL_G1_PLAIN = 2'h0,
    HSPL_G1_WARN = 2'h1,
    HSPL_G1_LAMP = 2'h2
  } hspl_g1_fn_t;
  // general pin 2 and 3 functions
  typedef enum logic [1:0] {
    HSPL_GX_OFF = 2'h0,
    HSPL_GX_CONN = 2'h1,
    HSPL_GX_ALERT = 2'h2,
    HSPL_GX_BUSEN = 2'h3
  } hspl_gx_fn_t;
endpackage : hspl_pkg
`default_nettype wire

// File: hdl/hspl_strap_decode.sv
// hspl_strap_decode.sv: turns the four straps into a bus address and mode.
// assumes: strap levels are caught once, by a clocked process after reset.
`default_nettype none
`include "hspl_params.svh"
module hspl_strap_decode
  import hspl_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] addr_strap_0_i,
  input  wire logic [1:0] addr_strap_1_i,
  input  wire logic [1:0] mode_strap_0_i,
  input  wire logic [1:0] mode_strap_1_i,
  output logic      [6:0] bus_addr_o,
  output logic            adaptive_mode_o,
  output logic            valid_o
);
  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  // map a strap code to 0..2 (illegal code reads as open)
  function automatic logic [1:0] strap_val(input logic [1:0] s);
    return (s == HSPL_STRAP_RES) ? 2'h2 : (s == HSPL_STRAP_GND) ? 2'h0 : 2'h1;
  endfunction

  // R15 nine addresses
  // R16 open selects fixed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_addr_o      <= 7'h00;
      adaptive_mode_o <= 1'b0;
      valid_o         <= 1'b0;
    end else if (!valid_o) begin
      bus_addr_o      <= `HSPL_ADDR_BASE | {3'h0, strap_val(addr_strap_1_i),
                                            strap_val(addr_strap_0_i)};
      adaptive_mode_o <= !(mode_strap_0_i == HSPL_STRAP_OPEN &&
                           mode_strap_1_i == HSPL_STRAP_OPEN);
      valid_o         <= 1'b1;
    end
  end
endmodule // hspl_strap_decode
`default_nettype wire

// File: hdl/hspl_od_pin.sv
// hspl_od_pin.sv: polarity inverter and open-drain driver for one pin.
// assumes: the board pulls the pin high when released.
`default_nettype none
module hspl_od_pin (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic assert_i,
  input  wire logic active_high_i,
  output logic      drive_low_oe_n_o
);
  // ----------------------------------------------------------------
  // pin driver
  // ----------------------------------------------------------------
  // R18 invert then drive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_low_oe_n_o <= 1'b1;
    end else begin
      drive_low_oe_n_o <= !(assert_i ^ active_high_i); // low = pull pin low
    end
  end
endmodule // hspl_od_pin
`default_nettype wire

// File: test/hspl_top_chk.sv
// hspl_top_chk.sv: port assertions for the hot-swap pin logic top.
// assumes: bound to hspl_top; one clock, synchronous reset high.
`default_nettype none
`include "hspl_params.svh"
module hspl_top_chk #(
  parameter int FAULTS = 8
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              cyc_i,
  input wire logic              stb_i,
  input wire logic              ack_o,
  input wire logic              undervolt_enable_in_i,
  input wire logic              overvolt_in_i,
  input wire logic [FAULTS-1:0] fault_i,
  input wire logic              gate_on_o,
  input wire logic              serial_data_in_i,
  input wire logic              serial_data_drive_low_i,
  input wire logic              serial_data_in_o,
  input wire logic              serial_data_out_oe_n_o,
  input wire logic        [1:0] addr_strap_0_i,
  input wire logic        [1:0] addr_strap_1_i,
  input wire logic        [1:0] mode_strap_0_i,
  input wire logic        [1:0] mode_strap_1_i,
  input wire logic        [6:0] bus_addr_o,
  input wire logic              adaptive_mode_o,
  input wire logic        [3:0] startup_limit_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // strap code to address bits
  // ----------------------------------------
  function automatic logic [1:0] sv(input logic [1:0] s);
    return (s == 2'h3) ? 2'h1 : s;
  endfunction
  property p_gate_window;
    (!undervolt_enable_in_i || overvolt_in_i) |=> !gate_on_o;
  endproperty
  a_gate_window: assert property (p_gate_window)
    else $error("gate on outside supply window");
  property p_gate_fault;
    (|fault_i) |=> !gate_on_o;
  endproperty
  a_gate_fault: assert property (p_gate_fault)
    else $error("gate on during fault");
  property p_ack_answer;
    (cyc_i && stb_i && !ack_o) |=> ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer)
    else $error("bus request not acknowledged next cycle");
  property p_sdi_copy;
    !$past(rst_i) |-> serial_data_in_o == $past(serial_data_in_i);
  endproperty
  a_sdi_copy: assert property (p_sdi_copy)
    else $error("serial data copy wrong");
  property p_sdo_release;
    !serial_data_drive_low_i |=> serial_data_out_oe_n_o;
  endproperty
  a_sdo_release: assert property (p_sdo_release)
    else $error("serial data out pulled without request");
  property p_strap_addr;
    $past(rst_i) |=> bus_addr_o ==
      ({3'h0, sv($past(addr_strap_1_i)), sv($past(addr_strap_0_i))} | `HSPL_ADDR_BASE);
  endproperty
  a_strap_addr: assert property (p_strap_addr)
    else $error("bus address decode wrong");
  property p_strap_mode;
    ($past(rst_i) && mode_strap_0_i == 2'h1 && mode_strap_1_i == 2'h1) |=> !adaptive_mode_o;
  endproperty
  a_strap_mode: assert property (p_strap_mode)
    else $error("open mode straps not fixed mode");
  property p_limit_fixed;
    !adaptive_mode_o |-> startup_limit_o == 4'h0;
  endproperty
  a_limit_fixed: assert property (p_limit_fixed)
    else $error("startup limit applied in fixed mode");
  c_gate_on: cover property ($rose(gate_on_o));
  c_ack: cover property (ack_o);
  c_sdo_low: cover property (!serial_data_out_oe_n_o);
endmodule // hspl_top_chk
bind hspl_top hspl_top_chk #(.FAULTS(FAULTS)) i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .undervolt_enable_in_i(undervolt_enable_in_i), .overvolt_in_i(overvolt_in_i),
  .fault_i(fault_i), .gate_on_o(gate_on_o), .serial_data_in_i(serial_data_in_i),
  .serial_data_drive_low_i(serial_data_drive_low_i), .serial_data_in_o(serial_data_in_o),
  .serial_data_out_oe_n_o(serial_data_out_oe_n_o), .addr_strap_0_i(addr_strap_0_i),
  .addr_strap_1_i(addr_strap_1_i), .mode_strap_0_i(mode_strap_0_i),
  .mode_strap_1_i(mode_strap_1_i), .bus_addr_o(bus_addr_o),
  .adaptive_mode_o(adaptive_mode_o), .startup_limit_o(startup_limit_o));
`default_nettype wire

// File: test/hspl_host_model.sv
// hspl_host_model.sv: bus host on the split serial data line.
// assumes: line pulled up; device drives its data output open-drain.
`default_nettype none
module hspl_host_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       send_i,
  input  wire logic [7:0] byte_i,
  input  wire logic       dev_oe_n_i,
  output logic            line_o,
  output logic            busy_o
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BitCyc = 40;
  logic [7:0] sh_q;
  logic [3:0] bit_q;
  logic [5:0] cyc_q;
  assign line_o = !((busy_o && !sh_q[7]) || !dev_oe_n_i);
  // shift one byte out, msb first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
    end else if (send_i && !busy_o) begin
      busy_o <= 1'b1;
      sh_q   <= byte_i;
      bit_q  <= 4'h0;
      cyc_q  <= 6'h0;
    end else if (busy_o && cyc_q == 6'(BitCyc - 1)) begin
      cyc_q  <= 6'h0;
      sh_q   <= {sh_q[6:0], 1'b1};
      bit_q  <= bit_q + 4'h1;
      busy_o <= (bit_q != 4'h7);
    end else if (busy_o) begin
      cyc_q <= cyc_q + 6'h1;
    end
  end
endmodule // hspl_host_model
`default_nettype wire

// File: test/hspl_top_tb.sv
// hspl_top_tb.sv: self-checking bench for the hot-swap pin logic.
// assumes: design, checker and host model compiled before it.
`default_nettype none
`include "hspl_params.svh"
module hspl_top_tb
  import hspl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [7:0]  adr_i, flt, wrn, tx, ctrl, cfg, fm, wm, am;
  logic [31:0] dat_i, dat_o, pv, r;
  logic        uv, ov, settled, enh, req, pin2, pin3, drv_low, send, busy;
  logic        sdi, sdi_o, sdo_oe_n, bus_en, gate, pg, g0, g1, g2, g3, adp;
  logic [3:0]  startup_current_set, lim;
  logic [1:0]  as0, as1, ms0, ms1;
  logic [31:0] rd_q[$], pin_q[$];
  int          err_count, tests_run, cycles;
  hspl_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .undervolt_enable_in_i(uv), .overvolt_in_i(ov), .output_settled_i(settled),
    .gate_enhanced_i(enh), .fault_i(flt), .warn_i(wrn), .gate_request_i(req),
    .startup_current_set_i(startup_current_set), .addr_strap_0_i(as0), .addr_strap_1_i(as1),
    .mode_strap_0_i(ms0), .mode_strap_1_i(ms1), .serial_data_in_i(sdi),
    .serial_data_drive_low_i(drv_low), .serial_data_in_o(sdi_o),
    .serial_data_out_oe_n_o(sdo_oe_n), .bus_enable_o(bus_en), .gate_on_o(gate),
    .power_good_out_oe_n_o(pg), .general_out_0_oe_n_o(g0), .general_out_1_oe_n_o(g1),
    .general_pin_2_i(pin2), .general_pin_2_oe_n_o(g2), .general_pin_3_i(pin3),
    .general_pin_3_oe_n_o(g3), .bus_addr_o(), .adaptive_mode_o(), .startup_limit_o(lim));
  hspl_host_model i_host (.clk_i(clk_i), .rst_i(rst_i), .send_i(send), .byte_i(tx),
    .dev_oe_n_i(sdo_oe_n), .line_o(sdi), .busy_o(busy));
  assign pv = {20'h0, lim, gate, pg, g0, g1, g2, g3, bus_en, sdi_o};
  assign adp = !(ms0 == 2'h1 && ms1 == 2'h1);
  initial clk_i = 1'b0;
  always #12.5 clk_i = ~clk_i;
  // open-drain enable: low when asserted at the active level is low
  function automatic logic od(input logic a, input logic ah);
    return a ~^ ah;
  endfunction
  // expected pin vector from shadow config and inputs
  function automatic logic [31:0] exp_pins(input logic sd);
    logic f, w, al, gt, e0, e1;
    f  = |(flt & fm);
    w  = |(wrn & wm);
    al = |((flt | wrn) & am);
    gt = req && uv && !ov && !(|flt) && !(cfg[5:4] == HSPL_GX_CONN && pin2);
    e0 = (cfg[1:0] == HSPL_G0_PLAIN) ? ctrl[3] : (cfg[1:0] == HSPL_G0_FAULT) ?
      od(f, ctrl[1]) : od(al, 1'b0);
    e1 = (cfg[3:2] == HSPL_G1_PLAIN) ? ctrl[4] : (cfg[3:2] == HSPL_G1_WARN) ?
      od(w, ctrl[2]) : od(f, 1'b0);
    return {20'h0, adp ? startup_current_set : 4'h0, gt, od(gt && settled && enh, ctrl[0]), e0, e1,
      (cfg[5:4] == HSPL_GX_ALERT) ? od(al, 1'b0) : 1'b1,
      (cfg[7:6] == HSPL_GX_ALERT) ? od(al, 1'b0) : 1'b1,
      (cfg[7:6] == HSPL_GX_BUSEN) ? pin3 : 1'b1, sd};
  endfunction
  // ----------------------------------------
  // bus master and checks
  // ----------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    wb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic chk_pins(input logic sd);
    repeat (3) @(posedge clk_i);
    pin_q.push_back(exp_pins(sd));
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    {ctrl, cfg, fm, wm, am} = {8'h00, 8'h04, 8'hff, 8'hff, 8'hff};
    @(posedge clk_i);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // monitor: oldest note against what the outputs show
  always @(negedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && rd_q.size() > 0) cmp("dat_o", rd_q.pop_front(), dat_o);
    if (pin_q.size() > 0) cmp("pins", pin_q.pop_front(), pv);
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 20000) begin
      err_count++;
      complete_run();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {cyc_i, stb_i, we_i, adr_i, dat_i, send, tx, drv_low} = '0;
    {uv, ov, settled, enh, req, pin2, pin3, flt, wrn, startup_current_set} = '0;
    {rst_i, as0, as1, ms0, ms1} = {1'b1, 8'h55};
    void'($urandom(32'h70d7));
    do_reset();
    rd(`HSPL_OFF_CTRL, `HSPL_CTRL_RST);
    rd(`HSPL_OFF_GPO_CFG, `HSPL_CFG_RST);
    rd(`HSPL_OFF_ALT_MASK, 32'h0000_00ff);
    rd(`HSPL_OFF_STRAPS, 32'h0000_0845);
    wb(1'b1, `HSPL_OFF_STRAPS, 32'hffff_ffff);
    rd(`HSPL_OFF_STRAPS, 32'h0000_0845);
    rd(8'h20, 32'h0000_0000);
    chk_pins(1'b1);
    $display("test reset values done");
    for (int i = 0; i < 36; i++) begin
      r = $urandom;
      ctrl = r[31:24] & 8'h1f;
      cfg = {(i % 3 == 0) ? 2'h0 : (i % 3 == 1) ? 2'h2 : 2'h3, 2'(i % 3), 2'((i / 3) % 3),
        2'((i / 4) % 3)};
      {fm, wm, am} = 24'($urandom);
      wb(1'b1, `HSPL_OFF_CTRL, {24'h0, ctrl});
      wb(1'b1, `HSPL_OFF_GPO_CFG, {24'h0, cfg});
      wb(1'b1, `HSPL_OFF_FLT_MASK, {24'h0, fm});
      wb(1'b1, `HSPL_OFF_WRN_MASK, {24'h0, wm});
      wb(1'b1, `HSPL_OFF_ALT_MASK, {24'h0, am});
      flt <= (r[1:0] == 2'h0) ? 8'($urandom) : 8'h00;
      wrn <= r[2] ? 8'($urandom) : 8'h00;
      {uv, ov, req} <= {r[3] | r[4], r[5] & r[6], r[7] | r[8]};
      {settled, enh, pin2, pin3, startup_current_set} <= {r[9] | r[10], r[11] | r[12], r[13], r[14], r[18:15]};
      chk_pins(1'b1);
    end
    $display("test pin functions done");
    {as0, as1} <= {2'($urandom % 3), 2'($urandom % 3)};
    {ms0, ms1} <= {2'($urandom % 3), 2'($urandom % 3)};
    do_reset();
    rd(`HSPL_OFF_STRAPS, {21'h1, adp, 3'h0, `HSPL_ADDR_BASE | {3'h0, as1, as0}});
    tx <= 8'($urandom);
    send <= 1'b1;
    @(posedge clk_i);
    send <= 1'b0;
    repeat (20) @(posedge clk_i);
    for (int b = 7; b >= 0; b--) begin
      pin_q.push_back(exp_pins(tx[b]));
      repeat (40) @(posedge clk_i);
    end
    drv_low <= 1'b1;
    chk_pins(1'b0);
    drv_low <= 1'b0;
    chk_pins(1'b1);
    $display("test serial line done");
    repeat (4) @(posedge clk_i);
    complete_run();
  end
endmodule // hspl_top_tb
`default_nettype wire
